// *** design/hts_regs.v ***
/*
 * Register bank and measurement control for a humidity/temperature sensor.
 * Assumes a serial port engine that presents decoded byte accesses on the
 * block clock (one-cycle strobes), a converter that reports each finished
 * sample with a one-cycle pulse, and a readable non-volatile trimming store.
 */
`timescale 1ns/10ps
`default_nettype none
`include "hts_regs_consts.vh"

module hts_regs #(
    parameter [7:0]  IDENTITY_CODE = 8'h5a, // Arbitrary value
    parameter [31:0] PERIOD_1HZ    = `HTS_PERIOD_1HZ,
    parameter [31:0] PERIOD_7HZ    = `HTS_PERIOD_7HZ,
    parameter [31:0] PERIOD_12HZ   = `HTS_PERIOD_12HZ
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        acc_start,
    input  wire [7:0]  acc_sub,
    input  wire        acc_wr,
    input  wire [7:0]  acc_wdata,
    input  wire        acc_rd,
    output reg  [7:0]  acc_rdata_q,
    output reg         acc_rvalid_q,
    output reg         conv_start_q,
    input  wire        conv_done,
    input  wire [15:0] conv_humidity,
    input  wire [15:0] conv_temperature,
    output reg  [2:0]  temp_average_select_q,
    output reg  [2:0]  humidity_average_select_q,
    output reg         active_enable_q,
    output reg         heater_on_q,
    output reg  [3:0]  nv_addr_q,
    input  wire [7:0]  nv_data,
    output reg         sample_ready_pin_o_q,
    output reg         sample_ready_pin_oe_q
);
    reg  [6:0]  addr_q;
    reg         inc_q;
    reg  [7:0]  avg_q;
    reg  [7:0]  ctrl1_q;
    reg  [7:0]  ctrl2_q;
    reg  [7:0]  ctrl3_q;
    reg         hda_q;
    reg         tda_q;
    reg  [15:0] hum_q;
    reg  [15:0] temp_q;
    reg         hum_lock_q;
    reg         temp_lock_q;
    reg         busy_q;
    reg  [31:0] rate_cnt_q;
    reg         boot_act_q;
    reg  [4:0]  boot_idx_q;
    reg         boot_wr_q;
    reg  [3:0]  boot_waddr_q;
    reg  [7:0]  rd_sel_q;
    reg         rd_trim_q;
    reg         rd_pend_q;
    localparam [7:0] AVG_RST = `HTS_RST_AVG_CONF;

    wire [7:0]  trim_rdata;
    wire        trim_host_wr;
    wire        mem_wr;
    wire [3:0]  mem_waddr;
    wire [7:0]  mem_wdata;
    wire [6:0]  cur_addr;
    wire        do_wr;
    wire        do_rd;
    wire [1:0]  output_rate_select;
    wire [31:0] period;
    wire        tick;
    wire        rd_hum_l;
    wire        rd_hum_h;
    wire        rd_temp_l;
    wire        rd_temp_h;
    wire        block_update;

    assign cur_addr  = acc_start ? acc_sub[6:0] : addr_q;
    assign do_wr     = acc_wr & ~boot_act_q;
    assign do_rd     = acc_rd;
    assign output_rate_select       = ctrl1_q[`HTS_ODR_MSB:`HTS_ODR_LSB];
    assign block_update       = ctrl1_q[`HTS_BDU_BIT];
    assign rd_hum_l  = do_rd && cur_addr == `HTS_ADDR_HUM_L;
    assign rd_hum_h  = do_rd && cur_addr == `HTS_ADDR_HUM_H;
    assign rd_temp_l = do_rd && cur_addr == `HTS_ADDR_TEMP_L;
    assign rd_temp_h = do_rd && cur_addr == `HTS_ADDR_TEMP_H;
    assign period    = (output_rate_select == `HTS_ODR_1HZ) ? PERIOD_1HZ :
                       (output_rate_select == `HTS_ODR_7HZ) ? PERIOD_7HZ : PERIOD_12HZ;
    assign tick      = active_enable_q && output_rate_select != `HTS_ODR_ONESHOT &&
                       rate_cnt_q >= period - 32'h0000_0001;
    assign trim_host_wr = do_wr &&
                          cur_addr[6:4] == `HTS_ADDR_TRIM_HI;
    // Reload has priority over host writes to the trimming area
    assign mem_wr    = boot_wr_q | trim_host_wr;
    assign mem_waddr = boot_wr_q ? boot_waddr_q : cur_addr[3:0];
    assign mem_wdata = boot_wr_q ? nv_data : acc_wdata;

    hts_trim_mem u_trim (
        .clk       (clk),
        .wr_en     (mem_wr),
        .wr_addr   (mem_waddr),
        .wr_data   (mem_wdata),
        .rd_addr   (cur_addr[3:0]),
        .rd_data_q (trim_rdata)
    );

    // Address pointer: auto-increment only when the sub-address asks for it
    always @(posedge clk) begin
        if (rst) begin
            addr_q <= 7'h00;
            inc_q  <= 1'b0;
        end else if (acc_start) begin
            inc_q  <= acc_sub[`HTS_SUB_INC_BIT];
            addr_q <= (acc_sub[`HTS_SUB_INC_BIT] && (acc_rd || acc_wr)) ?
                      acc_sub[6:0] + 7'h01 : acc_sub[6:0];
        end else if (inc_q && (acc_rd || acc_wr)) begin
            addr_q <= addr_q + 7'h01;
        end
    end

    // Writable control registers; reserved bits and addresses are dropped
    always @(posedge clk) begin
        if (rst) begin
            avg_q   <= `HTS_RST_AVG_CONF;
            ctrl1_q <= `HTS_RST_CTRL;
            ctrl2_q <= `HTS_RST_CTRL;
            ctrl3_q <= `HTS_RST_CTRL;
        end else begin
            if (do_wr && cur_addr == `HTS_ADDR_AVG_CONF) begin
                avg_q <= acc_wdata & `HTS_AVG_CONF_MASK;
            end
            if (do_wr && cur_addr == `HTS_ADDR_CTRL1) begin
                ctrl1_q <= acc_wdata & `HTS_CTRL1_MASK;
            end
            if (do_wr && cur_addr == `HTS_ADDR_CTRL3) begin
                ctrl3_q <= acc_wdata & `HTS_CTRL3_MASK;
            end
            if (do_wr && cur_addr == `HTS_ADDR_CTRL2) begin
                ctrl2_q <= acc_wdata & `HTS_CTRL2_MASK;
            end else begin
                // Self-clearing bits; a host write in the same cycle wins
                if (boot_act_q && boot_idx_q == 5'h10) begin
                    ctrl2_q[`HTS_BOOT_BIT] <= 1'b0;
                end
                if (conv_done && busy_q) begin
                    ctrl2_q[`HTS_ONESHOT_BIT] <= 1'b0;
                end
            end
        end
    end

    // Trimming reload: after reset and whenever the reboot bit is written
    always @(posedge clk) begin
        if (rst) begin
            boot_act_q   <= 1'b1;
            boot_idx_q   <= 5'h00;
            boot_wr_q    <= 1'b0;
            boot_waddr_q <= 4'h0;
            nv_addr_q    <= 4'h0;
        end else begin
            boot_wr_q    <= 1'b0;
            if (boot_act_q) begin
                // Store data lags the address by one cycle
                nv_addr_q  <= boot_idx_q[3:0] + 4'h1;
                boot_wr_q  <= ~boot_idx_q[4];
                boot_waddr_q <= boot_idx_q[3:0];
                if (boot_idx_q == 5'h10) begin
                    boot_act_q <= 1'b0;
                end else begin
                    boot_idx_q <= boot_idx_q + 5'h01;
                end
            end else if (do_wr && cur_addr == `HTS_ADDR_CTRL2 &&
                         acc_wdata[`HTS_BOOT_BIT]) begin
                boot_act_q <= 1'b1;
                boot_idx_q <= 5'h00;
                nv_addr_q  <= 4'h0;
            end
        end
    end

    // Conversion scheduling: single shot or free-running rate
    always @(posedge clk) begin
        if (rst) begin
            busy_q       <= 1'b0;
            rate_cnt_q   <= 32'h0000_0000;
            conv_start_q <= 1'b0;
        end else begin
            conv_start_q <= 1'b0;
            if (!active_enable_q || output_rate_select == `HTS_ODR_ONESHOT || tick) begin
                rate_cnt_q <= 32'h0000_0000;
            end else begin
                rate_cnt_q <= rate_cnt_q + 32'h0000_0001;
            end
            if (conv_done) begin
                busy_q <= 1'b0;
            end else if (!busy_q && active_enable_q &&
                         ((output_rate_select == `HTS_ODR_ONESHOT &&
                           ctrl2_q[`HTS_ONESHOT_BIT]) || tick)) begin
                busy_q       <= 1'b1;
                conv_start_q <= 1'b1;
            end
        end
    end

    // Result registers and sample-available flags
    always @(posedge clk) begin
        if (rst) begin
            hum_q       <= 16'h0000;
            temp_q      <= 16'h0000;
            hum_lock_q  <= 1'b0;
            temp_lock_q <= 1'b0;
            hda_q       <= 1'b0;
            tda_q       <= 1'b0;
        end else begin
            // Reading one byte locks the pair; the next read of either byte releases it
            if (!block_update || rd_hum_l == rd_hum_h) begin
                hum_lock_q <= hum_lock_q & block_update;
            end
            if (block_update && (rd_hum_l || rd_hum_h)) begin
                hum_lock_q <= ~hum_lock_q;
            end
            if (!block_update) begin
                temp_lock_q <= 1'b0;
            end else if (rd_temp_l || rd_temp_h) begin
                temp_lock_q <= ~temp_lock_q;
            end
            if (conv_done && !(block_update && hum_lock_q)) begin
                hum_q <= conv_humidity;
            end
            if (conv_done && !(block_update && temp_lock_q)) begin
                temp_q <= conv_temperature;
            end
            // A new sample wins over a clearing read in the same cycle
            hda_q <= conv_done | (hda_q & ~rd_hum_h);
            tda_q <= conv_done | (tda_q & ~rd_temp_h);
        end
    end

    // Read path: pick the byte, trimming data arrives one cycle later
    always @(posedge clk) begin
        if (rst) begin
            rd_sel_q     <= 8'h00;
            rd_trim_q    <= 1'b0;
            rd_pend_q    <= 1'b0;
            acc_rdata_q  <= 8'h00;
            acc_rvalid_q <= 1'b0;
        end else begin
            rd_pend_q <= do_rd;
            rd_trim_q <= cur_addr[6:4] == `HTS_ADDR_TRIM_HI;
            case (cur_addr)
                `HTS_ADDR_IDENTITY: rd_sel_q <= IDENTITY_CODE;
                `HTS_ADDR_AVG_CONF: rd_sel_q <= avg_q;
                `HTS_ADDR_CTRL1:    rd_sel_q <= ctrl1_q;
                `HTS_ADDR_CTRL2:    rd_sel_q <= ctrl2_q;
                `HTS_ADDR_CTRL3:    rd_sel_q <= ctrl3_q;
                `HTS_ADDR_STATUS:   rd_sel_q <= {6'h00, hda_q, tda_q};
                `HTS_ADDR_HUM_L:    rd_sel_q <= hum_q[7:0];
                `HTS_ADDR_HUM_H:    rd_sel_q <= hum_q[15:8];
                `HTS_ADDR_TEMP_L:   rd_sel_q <= temp_q[7:0];
                `HTS_ADDR_TEMP_H:   rd_sel_q <= temp_q[15:8];
                default:            rd_sel_q <= 8'h00;
            endcase
            acc_rvalid_q <= rd_pend_q;
            acc_rdata_q  <= rd_trim_q ? trim_rdata : rd_sel_q;
        end
    end

    // Field outputs and the ready pin
    always @(posedge clk) begin
        if (rst) begin
            temp_average_select_q     <=
                AVG_RST[`HTS_TEMP_AVERAGE_SELECT_MSB:`HTS_TEMP_AVERAGE_SELECT_LSB];
            humidity_average_select_q <=
                AVG_RST[`HTS_HUMIDITY_AVERAGE_SELECT_MSB:`HTS_HUMIDITY_AVERAGE_SELECT_LSB];
            active_enable_q           <= 1'b0;
            heater_on_q               <= 1'b0;
            sample_ready_pin_o_q      <= 1'b0;
            sample_ready_pin_oe_q     <= 1'b0;
        end else begin
            temp_average_select_q <=
                avg_q[`HTS_TEMP_AVERAGE_SELECT_MSB:`HTS_TEMP_AVERAGE_SELECT_LSB];
            humidity_average_select_q <=
                avg_q[`HTS_HUMIDITY_AVERAGE_SELECT_MSB:`HTS_HUMIDITY_AVERAGE_SELECT_LSB];
            active_enable_q <= ctrl1_q[`HTS_ACTIVE_BIT];
            heater_on_q     <= ctrl2_q[`HTS_HEATER_BIT];
            // Open-drain only drives the low level, whatever the polarity
            if (!ctrl3_q[`HTS_READY_OUTPUT_ENABLE_BIT]) begin
                sample_ready_pin_o_q  <= 1'b0;
                sample_ready_pin_oe_q <= 1'b0;
            end else begin
                sample_ready_pin_o_q <=
                    (hda_q | tda_q) ^ ctrl3_q[`HTS_POL_BIT];
                sample_ready_pin_oe_q <= !ctrl3_q[`HTS_OD_BIT] ||
                    ((hda_q | tda_q) ^ ctrl3_q[`HTS_POL_BIT]) == 1'b0;
            end
        end
    end
endmodule // hts_regs
`default_nettype wire

// *** design/hts_regs_consts.vh ***
/*
 * Constants for the humidity/temperature sensor register bank: register
 * addresses, field positions, reset values and timing counts.
 * Assumes a 10 MHz system clock; included by the register bank files.
 */
`ifndef HTS_REGS_CONSTS_VH
`define HTS_REGS_CONSTS_VH

`define HTS_ADDR_IDENTITY      7'h0f
`define HTS_ADDR_AVG_CONF      7'h10
`define HTS_ADDR_CTRL1         7'h20
`define HTS_ADDR_CTRL2         7'h21
`define HTS_ADDR_CTRL3         7'h22
`define HTS_ADDR_STATUS        7'h27
`define HTS_ADDR_HUM_L         7'h28
`define HTS_ADDR_HUM_H         7'h29
`define HTS_ADDR_TEMP_L        7'h2a
`define HTS_ADDR_TEMP_H        7'h2b
`define HTS_ADDR_TRIM_BASE     7'h30
`define HTS_ADDR_TRIM_HI       3'h3
`define HTS_SUB_INC_BIT        7

`define HTS_RST_AVG_CONF       8'h1b
`define HTS_RST_CTRL           8'h00
`define HTS_AVG_CONF_MASK      8'h3f
`define HTS_CTRL1_MASK         8'h87
`define HTS_CTRL2_MASK         8'h83
`define HTS_CTRL3_MASK         8'hc4

`define HTS_TEMP_AVERAGE_SELECT_MSB           5
`define HTS_TEMP_AVERAGE_SELECT_LSB           3
`define HTS_HUMIDITY_AVERAGE_SELECT_MSB           2
`define HTS_HUMIDITY_AVERAGE_SELECT_LSB           0
`define HTS_ACTIVE_BIT         7
`define HTS_BDU_BIT            2
`define HTS_ODR_MSB            1
`define HTS_ODR_LSB            0
`define HTS_BOOT_BIT           7
`define HTS_HEATER_BIT         1
`define HTS_ONESHOT_BIT        0
`define HTS_POL_BIT            7
`define HTS_OD_BIT             6
`define HTS_READY_OUTPUT_ENABLE_BIT        2
`define HTS_HDA_BIT            1
`define HTS_TDA_BIT            0

`define HTS_ODR_ONESHOT        2'h0
`define HTS_ODR_1HZ            2'h1
`define HTS_ODR_7HZ            2'h2
`define HTS_ODR_12HZ           2'h3

`define HTS_CLK_HZ             10000000
`define HTS_PERIOD_1HZ         (`HTS_CLK_HZ / 1)
`define HTS_PERIOD_7HZ         (`HTS_CLK_HZ / 7)
`define HTS_PERIOD_12HZ        ((`HTS_CLK_HZ * 2) / 25)
`define HTS_TRIM_WORDS         16
`define HTS_TRIM_AW            4

`endif

// *** design/hts_trim_mem.v ***
/*
 * Sixteen-byte trimming memory with one write port and a registered read.
 * Assumes both ports on the block clock; contents are undefined until the
 * first load from the non-volatile copy.
 */
`timescale 1ns/10ps
`default_nettype none
`include "hts_regs_consts.vh"

module hts_trim_mem (
    input  wire                      clk,
    input  wire                      wr_en,
    input  wire [`HTS_TRIM_AW-1:0]   wr_addr,
    input  wire [7:0]                wr_data,
    input  wire [`HTS_TRIM_AW-1:0]   rd_addr,
    output reg  [7:0]                rd_data_q
);
    reg [7:0] mem [0:`HTS_TRIM_WORDS-1];

    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end
endmodule // hts_trim_mem
`default_nettype wire

// *** testbench/hts_conv_model.sv ***
/* Converter and trim-store model for hts_regs.
   Assumes one clock; dly sets the conversion time in cycles. */
`timescale 1ns/10ps
`default_nettype none
module hts_conv_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  dly,
    input  wire logic        conv_start,
    output var  logic        conv_done,
    output wire logic [15:0] conv_humidity,
    output wire logic [15:0] conv_temperature,
    input  wire logic [3:0]  nv_addr,
    output var  logic [7:0]  nv_data
);
    logic [7:0] wait_q, n_q;
    logic       busy_q;
    // Inverse outside the done pulse so stale data cannot look valid
    assign conv_humidity    = conv_done ? {n_q, ~n_q} : {~n_q, n_q};
    assign conv_temperature = conv_done ? {~n_q, n_q} : {n_q, ~n_q};
    always @(posedge clk) begin
        // Store answers one cycle after the address, as the reload expects
        nv_data   <= {4'ha, nv_addr};
        conv_done <= 1'b0;
        if (rst) begin
            busy_q <= 1'b0;
            n_q    <= 8'h00;
        end else if (conv_start) begin
            busy_q <= 1'b1;
            wait_q <= dly;
        end else if (busy_q) begin
            if (wait_q == 8'h00) begin
                busy_q    <= 1'b0;
                conv_done <= 1'b1;
            end else begin
                wait_q <= wait_q - 8'h01;
            end
        end
        if (conv_done && !rst) n_q <= n_q + 8'h01;
    end
endmodule // hts_conv_model
`default_nettype wire

// *** testbench/hts_regs_props.sv ***
/* Port-timing checker for hts_regs.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module hts_regs_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        acc_start,
    input wire logic [7:0]  acc_sub,
    input wire logic        acc_wr,
    input wire logic [7:0]  acc_wdata,
    input wire logic        acc_rd,
    input wire logic [7:0]  acc_rdata_q,
    input wire logic        acc_rvalid_q,
    input wire logic        conv_start_q,
    input wire logic        conv_done,
    input wire logic [15:0] conv_humidity,
    input wire logic [15:0] conv_temperature,
    input wire logic [2:0]  temp_average_select_q,
    input wire logic [2:0]  humidity_average_select_q,
    input wire logic        active_enable_q,
    input wire logic        heater_on_q,
    input wire logic [3:0]  nv_addr_q,
    input wire logic [7:0]  nv_data,
    input wire logic        sample_ready_pin_o_q,
    input wire logic        sample_ready_pin_oe_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_RD_LATENCY: assert property (acc_rd |-> ##2 acc_rvalid_q)
        else $error("read answer missing");
    AST_RVALID_CAUSE: assert property (
        acc_rvalid_q |-> $past(acc_rd, 2))
        else $error("read answer without request");
    AST_START_PULSE: assert property (conv_start_q |=> !conv_start_q)
        else $error("start longer than one cycle");
    AST_START_ACTIVE: assert property (
        conv_start_q |-> $past(active_enable_q))
        else $error("start while powered down");
    AST_ONE_OUTSTANDING: assert property (
        conv_start_q ##1 !conv_done |=> !conv_start_q)
        else $error("start while busy");
    // Field outputs trail the write strobe by two edges
    AST_HEATER_HOST: assert property (
        $changed(heater_on_q) |-> $past(acc_wr, 2))
        else $error("heater moved without write");
    AST_ACTIVE_HOST: assert property (
        $changed(active_enable_q) |-> $past(acc_wr, 2))
        else $error("power mode moved without write");
    AST_TAVG_HOST: assert property (
        $changed(temp_average_select_q) |-> $past(acc_wr, 2))
        else $error("temperature average moved");
    AST_HAVG_HOST: assert property (
        $changed(humidity_average_select_q) |-> $past(acc_wr, 2))
        else $error("humidity average moved");
    AST_RESET_VALUES: assert property (
        disable iff (1'b0) rst |=> temp_average_select_q == 3'h3 &&
        humidity_average_select_q == 3'h3 && !active_enable_q &&
        !heater_on_q)
        else $error("wrong reset values");
    cover property (conv_done);
    cover property (acc_rd ##1 acc_rd);
    cover property (sample_ready_pin_oe_q && !sample_ready_pin_o_q);
endmodule // hts_regs_props
bind hts_regs hts_regs_props i_props (.clk(clk), .rst(rst),
    .acc_start(acc_start), .acc_sub(acc_sub), .acc_wr(acc_wr),
    .acc_wdata(acc_wdata), .acc_rd(acc_rd), .acc_rdata_q(acc_rdata_q),
    .acc_rvalid_q(acc_rvalid_q), .conv_start_q(conv_start_q),
    .conv_done(conv_done), .conv_humidity(conv_humidity),
    .conv_temperature(conv_temperature),
    .temp_average_select_q(temp_average_select_q),
    .humidity_average_select_q(humidity_average_select_q),
    .active_enable_q(active_enable_q), .heater_on_q(heater_on_q),
    .nv_addr_q(nv_addr_q), .nv_data(nv_data),
    .sample_ready_pin_o_q(sample_ready_pin_o_q),
    .sample_ready_pin_oe_q(sample_ready_pin_oe_q));
`default_nettype wire

// *** testbench/tb.sv ***
/* Self-checking bench for hts_regs.
   Assumes shortened rate periods and the converter model beside it. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [7:0] ID = 8'ha6; // Arbitrary value
    localparam int P1 = 40, P7 = 28, P12 = 16;
    logic        clk, rst, acc_start, acc_wr, acc_rd, acc_rvalid_q, cst;
    logic        conv_done, act, heat, pin_o, pin_oe;
    logic [7:0]  acc_sub, acc_wdata, acc_rdata_q, nv_data, dly;
    logic [15:0] hum, tmp, d;
    logic [2:0]  tavg, havg;
    logic [3:0]  nv_addr;
    int          fails, num_checks, sn, cyc, k, t0;
    logic [31:0] rows [12] = '{32'h0010_001b, 32'h0020_0000, 32'h0021_0000,
        32'h0022_0000, 32'h0027_0000, 32'h0035_00a5, 32'h003f_00af,
        {16'h010f, 8'hff, ID}, 32'h0110_ff3f, 32'h0012_0000,
        32'h0122_ffc4, 32'h0122_0000};
    hts_regs #(.IDENTITY_CODE(ID), .PERIOD_1HZ(P1), .PERIOD_7HZ(P7),
        .PERIOD_12HZ(P12)) i_hts_regs (.clk(clk), .rst(rst),
        .acc_start(acc_start), .acc_sub(acc_sub), .acc_wr(acc_wr),
        .acc_wdata(acc_wdata), .acc_rd(acc_rd), .acc_rdata_q(acc_rdata_q),
        .acc_rvalid_q(acc_rvalid_q), .conv_start_q(cst),
        .conv_done(conv_done), .conv_humidity(hum), .conv_temperature(tmp),
        .temp_average_select_q(tavg), .humidity_average_select_q(havg),
        .active_enable_q(act), .heater_on_q(heat), .nv_addr_q(nv_addr),
        .nv_data(nv_data), .sample_ready_pin_o_q(pin_o),
        .sample_ready_pin_oe_q(pin_oe));
    hts_conv_model i_hts_conv_model (.clk(clk), .rst(rst), .dly(dly),
        .conv_start(cst), .conv_done(conv_done), .conv_humidity(hum),
        .conv_temperature(tmp), .nv_addr(nv_addr), .nv_data(nv_data));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        sn  <= rst ? 0 : sn + int'(conv_done);
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        acc_start <= 1'b1;
        acc_sub   <= a;
        acc_wr    <= 1'b1;
        acc_wdata <= v;
        @(posedge clk);
        acc_start <= 1'b0;
        acc_wr    <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    // Bytes arrive low first; a single byte lands in d[15:8]
    task automatic rd(input logic [7:0] a, input int n, output logic [15:0] v);
        int i, got;
        got = 0;
        v = 16'h0000;
        for (i = 0; i < 10 && got < n; i++) begin
            @(posedge clk);
            acc_start <= (i == 0);
            acc_sub   <= a;
            acc_rd    <= (i < n);
            #1;
            if (acc_rvalid_q) begin
                v = {acc_rdata_q, v[15:8]};
                got++;
            end
        end
        if (got < n) begin
            fails++;
            end_of_test();
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        rd(a, 1, d);
        chk(d[15:8], exp);
    endtask
    task automatic wait_done;
        for (k = 0; k < 300 && conv_done !== 1'b1; k++) @(posedge clk) #1;
        if (k == 300) begin
            fails++;
            end_of_test();
        end
        @(posedge clk);
        #1;
    endtask
    initial begin
        {rst, acc_start, acc_wr, acc_rd, acc_sub, acc_wdata} = 20'h8_0000;
        {fails, num_checks} = 0;
        dly = 8'h03;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (18) @(posedge clk);
        // Reserved bits are written with ones; the reserved address is only read
        foreach (rows[i]) begin
            if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
            rchk(rows[i][23:16], rows[i][7:0]);
        end
        for (int c = 0; c < 8; c++) begin
            wr(8'h10, {2'h0, c[2:0], 3'h7 - c[2:0]});
            chk({tavg, havg}, {c[2:0], 3'h7 - c[2:0]});
        end
        wr(8'h21, 8'h02);
        chk(heat, 1'b1);
        wr(8'h21, 8'h00); // Heater off before any data read
        wr(8'h22, 8'h04);
        wr(8'h21, 8'h01);
        repeat (30) @(posedge clk);
        chk({sn[7:0], pin_o, pin_oe}, 10'h001);
        dly = 8'h28;
        wr(8'h20, 8'h80);
        wait_done();
        rchk(8'h21, 8'h00);
        rchk(8'h27, 8'h03);
        chk(pin_o, 1'b1);
        rd(8'ha8, 2, d);
        chk(d, {sn[7:0] - 8'h01, ~(sn[7:0] - 8'h01)});
        rchk(8'h27, 8'h01);
        chk(pin_o, 1'b1);
        rd(8'haa, 2, d);
        chk(d, {~(sn[7:0] - 8'h01), sn[7:0] - 8'h01});
        chk({pin_o, pin_oe}, 2'h1);
        dly = 8'h03;
        wr(8'h22, 8'hc4);
        chk(pin_oe, 1'b0);
        wr(8'h21, 8'h01);
        wait_done();
        @(posedge clk) #1;
        chk({pin_o, pin_oe}, 2'h1);
        // Pair lock in force: reads may straddle a sample
        wr(8'h20, 8'h85);
        wait_done();
        rchk(8'h28, ~(sn[7:0] - 8'h01));
        wait_done();
        rchk(8'h27, 8'h03);
        rchk(8'h29, sn[7:0] - 8'h02);
        wr(8'h20, 8'h81);
        rd(8'h28, 1, d);
        wait_done();
        rchk(8'h29, sn[7:0] - 8'h01);
        for (int r = 1; r < 4; r++) begin
            wr(8'h20, 8'h80 | r[7:0]);
            wait_done();
            t0 = cyc;
            wait_done();
            chk(cyc - t0, r == 1 ? P1 : r == 2 ? P7 : P12);
        end
        wr(8'h20, 8'h00);
        wr(8'h21, 8'h80);
        repeat (20) @(posedge clk);
        rchk(8'h21, 8'h00);
        rchk(8'h3c, 8'hac);
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (18) @(posedge clk);
        rchk(8'h10, 8'h1b);
        rchk(8'h22, 8'h00);
        end_of_test();
    end
endmodule // tb
`default_nettype wire
